// ---- hw/port_map_map.svh ----
// Port addresses, field positions, reset values and memory constants
`ifndef PORT_MAP_MAP_SVH
`define PORT_MAP_MAP_SVH
`define PA_PORT_A_DATA 6'h00
`define PA_PORT_A_DIR 6'h04
`define PA_PORT_B_DATA 6'h08
`define PA_PORT_B_DIR 6'h0C
`define PA_PORT_C_DATA 6'h10
`define PA_PORT_C_DIR 6'h14
`define PA_PORT_D_DATA 6'h18
`define PA_PORT_D_DIR 6'h1C
`define PA_PORT_E_DATA 6'h20
`define PA_PORT_E_DIR 6'h24
`define PA_PORT_F_LEVELS 6'h28
`define PA_PORT_G_LATCH 6'h2C
`define PA_OSC_TRIM 6'h2F
`define PA_CONV_SAMPLE 6'h30
`define PA_CONV_CTRL 6'h34
`define PA_INT_GEN_CTRL 6'h38
`define PA_INT_PENDING 6'h39
`define PA_T1_RELOAD 6'h3A
`define PA_T1_COUNT 6'h3B
`define PA_CLK_SPEED 6'h3D
`define PA_T2_RELOAD 6'h3E
`define PA_T2_COUNT 6'h3F
`define RST_DIR 8'h00
`define RST_WORD16 16'h0000
`define RST_TRIM 17'h00000
`define RST_CONV_CTRL 4'h0
`define ROM_VECTOR_BASE 15'h7FF0
`define ROM_PROT_ADDR 15'h7FFE
`define ROM_RESET_ADDR 15'h7FFF
`define ROM_TEST_WORDS 15'h0800
`define ROM_BLOCK_SHIFT 9
`define PW_FM_LSB 0
`define PW_BP_BIT 7
`define PW_GP_BIT 8
`define PW_TM_LSB 9
`define IMR_LSB 0
`define CONV_SAMPLE_SHIFT 0
`endif

// ---- hw/port_map_pkg.sv ----
// Types shared by the memory organisation block
package port_map_pkg;
    typedef enum logic [1:0] {
        ST_PROT_FETCH = 2'b00,
        ST_PROT_LATCH = 2'b01,
        ST_VEC_FETCH = 2'b10,
        ST_RUN = 2'b11
    } boot_state_e;
    typedef logic [14:0] rom_addr_t;
    typedef logic [16:0] rom_word_t;
endpackage

// ---- hw/port_map_vectors_rom_security.sv ----
// Port map, ROM vectors and ROM security for the processor core
// Summary of operation
// - Program ROM 32K words of 17 bits
// - Data RAM 640 words, 16 data + flag
// - Fetches come only from internal ROM
// - Port writes store low-order right-justified bits
// - Port reads right-justified, upper bits zero
// - Converter sample unused bits below value
// - Direction registers reset to all inputs
// - Input pins read external levels
// - Pending flags survive reset
// - Trim location read-only, resets zero; this block has no trim register and reads i_trim_value[15:0]
// - Taken interrupt loads its vector word
// - Eight vectors 0x7FF0-0x7FF7, descending priority
// - Vector branch needs its mask bit
// - Reset release loads start vector 0x7FFF
// - 0x7FFE holds the protection word
// - Partition splits ROM at m times 512
// - Guard bits bar scan access per block
// - Partition fixed once block guard engaged
// - Lookups barred against protected memory
// - Lookups valid only within same block
// - Whole guard zero blocks all memory
// - Block guard blocks below (marker+1)*512
// - Protection word latched before execution
`timescale 1ns/100ps
`include "port_map_map.svh"
module port_map_vectors_rom_security
    import port_map_pkg::*;
#(
    parameter int RAM_WORDS = 640,
    parameter int DAC_BITS = 16
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Core port transfers
    input wire logic i_port_wr,
    input wire logic i_port_rd,
    input wire logic [5:0] i_port_addr,
    input wire logic [15:0] i_port_wdata,
    output logic [15:0] o_port_rdata,
    // Core program fetch and lookup
    input wire logic [14:0] i_fetch_addr,
    output logic [16:0] o_fetch_data,
    input wire logic i_lookup,
    input wire logic [14:0] i_lookup_addr,
    output logic [16:0] o_lookup_data,
    output logic o_lookup_fault,
    // Scan path access
    input wire logic i_scan_rd,
    input wire logic [14:0] i_scan_addr,
    output logic [16:0] o_scan_data,
    output logic o_scan_denied,
    // Data RAM
    input wire logic i_ram_wr,
    input wire logic [9:0] i_ram_addr,
    input wire logic [16:0] i_ram_wdata,
    output logic [16:0] o_ram_rdata,
    // Interrupt service
    input wire logic i_global_int_en,
    input wire logic i_int_ack,
    input wire logic [7:0] i_int_events,
    output logic o_int_take,
    output logic [2:0] o_int_level,
    // Program counter load
    output logic o_pc_load,
    output logic [14:0] o_pc_value,
    output logic o_core_run,
    // Pins of ports A to E, F and G
    input wire logic [39:0] i_pin_levels,
    output logic [39:0] o_pin_out,
    output logic [39:0] o_pin_oe,
    input wire logic [7:0] i_port_f_levels,
    output logic [15:0] o_port_g,
    // Peripheral registers to their owners
    input wire logic [16:0] i_trim_value,
    output logic [15:0] o_conv_sample,
    output logic [3:0] o_conv_ctrl,
    output logic [15:0] o_int_gen_ctrl,
    output logic [15:0] o_t1_reload,
    output logic [15:0] o_t2_reload,
    output logic [15:0] o_clk_speed,
    input wire logic [15:0] i_t1_count,
    input wire logic [15:0] i_t2_count,
    output logic o_t1_count_wr,
    output logic o_t2_count_wr
);
    // ----------------------------------------
    // Memories
    // ----------------------------------------
    // Program image held whole; lowest words kept for test code
    rom_word_t rom [0:32767];
    logic [16:0] ram [0:RAM_WORDS-1];
    logic [16:0] prot_word;
    logic scan_block;
    logic lookup_block;
    boot_state_e boot;

    initial begin
        for (int k = 0; k < 32768; k++) begin
            rom[k] = 17'h1FFFF;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_ram_wr) begin
            ram[i_ram_addr] <= i_ram_wdata;
        end
        o_ram_rdata <= ram[i_ram_addr];
    end

    // Fetch never leaves the internal array
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_fetch_data <= 17'h00000;
        end else begin
            o_fetch_data <= rom[i_fetch_addr];
        end
    end

    // ----------------------------------------
    // Security
    // ----------------------------------------
    rom_guard u_guard (
        .i_prot_word(prot_word),
        .i_addr(i_lookup ? i_lookup_addr : i_scan_addr),
        .i_origin(i_fetch_addr),
        .o_scan_block(scan_block),
        .o_lookup_block(lookup_block)
    );

    // Read-only word; reset reloads it so the state is always known
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            boot <= ST_PROT_FETCH;
            prot_word <= 17'h00000;
        end else begin
            case (boot)
                ST_PROT_FETCH: boot <= ST_PROT_LATCH;
                ST_PROT_LATCH: begin
                    prot_word <= rom[`ROM_PROT_ADDR];
                    boot <= ST_VEC_FETCH;
                end
                ST_VEC_FETCH: boot <= ST_RUN;
                ST_RUN: boot <= ST_RUN;
                default: boot <= ST_PROT_FETCH;
            endcase
        end
    end
    assign o_core_run = boot == ST_RUN;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_lookup_data <= 17'h00000;
            o_lookup_fault <= 1'b0;
            o_scan_data <= 17'h00000;
            o_scan_denied <= 1'b0;
        end else begin
            o_lookup_fault <= i_lookup && lookup_block;
            o_lookup_data <= (i_lookup && !lookup_block) ?
                rom[i_lookup_addr] : 17'h00000;
            o_scan_denied <= i_scan_rd && !i_lookup && scan_block;
            o_scan_data <= (i_scan_rd && !i_lookup && !scan_block) ?
                rom[i_scan_addr] : 17'h00000;
        end
    end

    // ----------------------------------------
    // Port registers
    // ----------------------------------------
    logic [7:0] pdata [0:4];
    logic [7:0] pdir [0:4];
    logic [7:0] pend;
    logic [7:0] next_pend;

    function automatic logic [2:0] port_idx(input logic [5:0] a);
        port_idx = a[5:3];
    endfunction

    // Data latches have no reset value
    always_ff @(posedge i_core_clk) begin
        for (int p = 0; p < 5; p++) begin
            if (i_port_wr && i_port_addr[5:3] == 3'(p) &&
                i_port_addr[2:0] == 3'b000) begin
                pdata[p] <= i_port_wdata[7:0];
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        for (int p = 0; p < 5; p++) begin
            if (i_rst) begin
                pdir[p] <= `RST_DIR;
            end else if (i_port_wr && i_port_addr[5:3] == 3'(p) &&
                i_port_addr[2:0] == 3'b100) begin
                pdir[p] <= i_port_wdata[7:0];
            end
        end
    end

    always_comb begin
        for (int p = 0; p < 5; p++) begin
            o_pin_out[p*8 +: 8] = pdata[p];
            o_pin_oe[p*8 +: 8] = pdir[p];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_port_g <= `RST_WORD16;
            o_conv_sample <= `RST_WORD16;
            o_conv_ctrl <= `RST_CONV_CTRL;
            o_int_gen_ctrl <= `RST_WORD16;
            o_t1_reload <= `RST_WORD16;
            o_t2_reload <= `RST_WORD16;
            o_clk_speed <= `RST_WORD16;
        end else if (i_port_wr) begin
            case (i_port_addr)
                `PA_PORT_G_LATCH: o_port_g <= i_port_wdata;
                // Value left-justified, spare bits sit below
                `PA_CONV_SAMPLE: o_conv_sample <= {i_port_wdata[DAC_BITS-1:0],
                    {(16-DAC_BITS){1'b0}}};
                `PA_CONV_CTRL: o_conv_ctrl <= i_port_wdata[3:0];
                `PA_INT_GEN_CTRL: o_int_gen_ctrl <= i_port_wdata;
                `PA_T1_RELOAD: o_t1_reload <= i_port_wdata;
                `PA_T2_RELOAD: o_t2_reload <= i_port_wdata;
                `PA_CLK_SPEED: o_clk_speed <= i_port_wdata;
                default: o_port_g <= o_port_g;
            endcase
        end
    end
    assign o_t1_count_wr = i_port_wr && i_port_addr == `PA_T1_COUNT;
    assign o_t2_count_wr = i_port_wr && i_port_addr == `PA_T2_COUNT;

    // Events win over a software clear in the same cycle
    always_comb begin
        next_pend = pend;
        if (i_port_wr && i_port_addr == `PA_INT_PENDING) begin
            next_pend = i_port_wdata[7:0];
        end
        if (o_int_take && i_int_ack) begin
            next_pend[o_int_level] = 1'b0;
        end
        next_pend = next_pend | i_int_events;
    end

    // Not reset: pending flags persist through reset
    always_ff @(posedge i_core_clk) begin
        pend <= next_pend;
    end

    // ----------------------------------------
    // Port read
    // ----------------------------------------
    function automatic logic [7:0] mix_pins(input logic [7:0] dir,
        input logic [7:0] lat, input logic [7:0] pin);
        mix_pins = (dir & lat) | (~dir & pin);
    endfunction

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_port_rdata <= 16'h0000;
        end else if (i_port_rd) begin
            o_port_rdata <= 16'h0000;
            case (i_port_addr)
                `PA_PORT_A_DATA, `PA_PORT_B_DATA, `PA_PORT_C_DATA,
                `PA_PORT_D_DATA, `PA_PORT_E_DATA:
                    o_port_rdata <= {8'h00, mix_pins(
                        pdir[port_idx(i_port_addr)],
                        pdata[port_idx(i_port_addr)],
                        i_pin_levels[port_idx(i_port_addr)*8 +: 8])};
                `PA_PORT_A_DIR, `PA_PORT_B_DIR, `PA_PORT_C_DIR,
                `PA_PORT_D_DIR, `PA_PORT_E_DIR:
                    o_port_rdata <= {8'h00, pdir[port_idx(i_port_addr)]};
                `PA_PORT_F_LEVELS: o_port_rdata <= {8'h00, i_port_f_levels};
                `PA_PORT_G_LATCH: o_port_rdata <= o_port_g;
                // Seventeenth trim bit does not fit the accumulator
                `PA_OSC_TRIM: o_port_rdata <= i_trim_value[15:0];
                `PA_CONV_CTRL: o_port_rdata <= {12'h000, o_conv_ctrl};
                `PA_INT_GEN_CTRL: o_port_rdata <= o_int_gen_ctrl;
                `PA_INT_PENDING: o_port_rdata <= {8'h00, pend};
                `PA_T1_RELOAD: o_port_rdata <= o_t1_reload;
                `PA_T1_COUNT: o_port_rdata <= i_t1_count;
                `PA_T2_RELOAD: o_port_rdata <= o_t2_reload;
                `PA_T2_COUNT: o_port_rdata <= i_t2_count;
                default: o_port_rdata <= 16'h0000;
            endcase
        end
    end

    // ----------------------------------------
    // Vectors
    // ----------------------------------------
    logic [7:0] ready_lv;
    logic [2:0] pick;

    assign ready_lv = pend & o_int_gen_ctrl[`IMR_LSB +: 8];

    // Lowest index is highest priority
    always_comb begin
        pick = 3'd0;
        for (int i = 7; i >= 0; i--) begin
            if (ready_lv[i]) begin
                pick = 3'(i);
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_int_take <= 1'b0;
            o_int_level <= 3'd0;
        end else begin
            o_int_take <= o_core_run && i_global_int_en && |ready_lv
                && !(o_int_take && i_int_ack);
            o_int_level <= pick;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_pc_load <= 1'b0;
            o_pc_value <= 15'h0000;
        end else if (boot == ST_VEC_FETCH) begin
            o_pc_load <= 1'b1;
            o_pc_value <= rom[`ROM_RESET_ADDR][14:0];
        end else if (o_int_take && i_int_ack) begin
            o_pc_load <= 1'b1;
            o_pc_value <= rom[`ROM_VECTOR_BASE + {12'h000, o_int_level}]
                [14:0];
        end else begin
            o_pc_load <= 1'b0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_boot_done;
        boot == ST_VEC_FETCH ##1 o_pc_load;
    endsequence

    a_reset_vector: assert property (@(posedge i_core_clk)
        $fell(i_rst) |-> ##2 s_boot_done)
        else $error("reset vector not loaded");
    a_run_gated: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_int_take |-> o_core_run)
        else $error("interrupt before security known");
    a_dir_reset: assert property (@(posedge i_core_clk)
        i_rst |=> pdir[0] == 8'h00 && pdir[4] == 8'h00)
        else $error("direction not cleared");
    a_mask_needed: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_int_take |-> $past(o_int_gen_ctrl[pick]))
        else $error("masked level taken");
    a_global_block: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !prot_word[`PW_GP_BIT] && i_scan_rd && !i_lookup |=>
        o_scan_denied)
        else $error("global guard leak");
    a_lookup_fault: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_lookup && lookup_block |=> o_lookup_fault && o_lookup_data == 0)
        else $error("lookup not refused");
    a_unmapped_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_port_rd && i_port_addr == `PA_CONV_SAMPLE |=> o_port_rdata == 0)
        else $error("write-only read nonzero");
    a_read_narrow: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_port_rd && i_port_addr == `PA_INT_PENDING |=>
        o_port_rdata[15:8] == 8'h00)
        else $error("upper bits not cleared");
endmodule

// ---- hw/rom_guard.sv ----
// Program memory access guard from the protection word
`timescale 1ns/100ps
`include "port_map_map.svh"
module rom_guard
    import port_map_pkg::*;
(
    // Latched protection word
    input wire logic [16:0] i_prot_word,
    // Access under check
    input wire logic [14:0] i_addr,
    input wire logic [14:0] i_origin,
    // Verdicts
    output logic o_scan_block,
    output logic o_lookup_block
);
    logic bp_n;
    logic gp_n;
    logic [5:0] marker;
    logic [15:0] boundary;
    logic addr_low;
    logic origin_low;

    // Zero value protects, erased cells read one
    assign bp_n = i_prot_word[`PW_BP_BIT];
    assign gp_n = i_prot_word[`PW_GP_BIT];
    assign marker = i_prot_word[`PW_TM_LSB +: 6];
    // (marker+1)*512 as the first unguarded word
    assign boundary = {3'b000, 4'b0000, marker, 3'b000} * 16'h0040
        + 16'h0200;
    assign addr_low = {1'b0, i_addr} < boundary;
    assign origin_low = {1'b0, i_origin} < boundary;

    always_comb begin
        o_scan_block = 1'b0;
        if (!gp_n) begin
            o_scan_block = 1'b1;
        end else if (!bp_n) begin
            o_scan_block = addr_low;
        end
    end

    // Lookups must stay within the caller's own block
    always_comb begin
        o_lookup_block = 1'b0;
        if (!gp_n) begin
            o_lookup_block = 1'b1;
        end else if (!bp_n) begin
            o_lookup_block = addr_low != origin_low;
        end
    end
endmodule

// ---- tb/core_model.sv ----
// Processor core model issuing port transfers
`timescale 1ns/100ps
module core_model (
    // Clock
    input wire logic i_core_clk,
    // Port transfer side
    output logic o_port_wr,
    output logic o_port_rd,
    output logic [5:0] o_port_addr,
    output logic [15:0] o_port_wdata,
    input wire logic [15:0] i_port_rdata
);
    initial begin
        o_port_wr = 1'b0;
        o_port_rd = 1'b0;
        o_port_addr = 6'h3C;
        o_port_wdata = 16'h0000;
    end
    // Released data lines show the inverse, never a stale copy
    task automatic put(input logic [5:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        o_port_wr <= 1'b1;
        o_port_addr <= a;
        o_port_wdata <= d;
        @(posedge i_core_clk);
        o_port_wr <= 1'b0;
        o_port_wdata <= ~d;
        #1;
    endtask
    task automatic get(input logic [5:0] a, output logic [15:0] d);
        @(posedge i_core_clk);
        o_port_rd <= 1'b1;
        o_port_addr <= a;
        @(posedge i_core_clk);
        o_port_rd <= 1'b0;
        #1;
        d = i_port_rdata;
    endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the port map, vectors and ROM security block
`timescale 1ns/100ps
module tb;
    // ------------------------------------------------
    // Signals
    // ------------------------------------------------
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_port_wr, i_port_rd, i_lookup, i_scan_rd, i_ram_wr;
    logic i_global_int_en, i_int_ack, o_lookup_fault, o_scan_denied;
    logic o_int_take, o_pc_load, o_core_run, o_t1_count_wr, o_t2_count_wr;
    logic [5:0] i_port_addr;
    logic [15:0] i_port_wdata, o_port_rdata, rd;
    logic [14:0] i_fetch_addr, i_lookup_addr, i_scan_addr, o_pc_value;
    logic [16:0] o_fetch_data, o_lookup_data, o_scan_data, o_ram_rdata;
    logic [16:0] i_ram_wdata, i_trim_value;
    logic [9:0] i_ram_addr;
    logic [7:0] i_int_events, i_port_f_levels;
    logic [2:0] o_int_level;
    logic [39:0] i_pin_levels, o_pin_out, o_pin_oe;
    logic [15:0] o_port_g, o_conv_sample, o_int_gen_ctrl, o_t1_reload;
    logic [15:0] o_t2_reload, o_clk_speed, i_t1_count, i_t2_count;
    logic [3:0] o_conv_ctrl;
    logic [5:0] rst_addr [10] = '{6'h04, 6'h0C, 6'h14, 6'h1C, 6'h24,
        6'h2C, 6'h2F, 6'h30, 6'h34, 6'h3D};
    logic [5:0] rw_addr [9] = '{6'h04, 6'h0C, 6'h14, 6'h1C, 6'h24,
        6'h2C, 6'h34, 6'h3A, 6'h3E};
    logic [15:0] rw_mask [9] = '{16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF,
        16'h00FF, 16'hFFFF, 16'h000F, 16'hFFFF, 16'hFFFF};
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;
    int t1_wr_seen = 0;
    int t2_wr_seen = 0;
    // Count write strobes to the external timer counters
    always @(posedge i_core_clk) begin
        if (o_t1_count_wr === 1'b1) t1_wr_seen <= t1_wr_seen + 1;
        if (o_t2_count_wr === 1'b1) t2_wr_seen <= t2_wr_seen + 1;
    end
    // ------------------------------------------------
    // Device and core
    // ------------------------------------------------
    // Narrow converter width so the left shift is visible
    port_map_vectors_rom_security #(.DAC_BITS(12)) dut (.*);
    core_model core (
        .i_core_clk(i_core_clk),
        .o_port_wr(i_port_wr),
        .o_port_rd(i_port_rd),
        .o_port_addr(i_port_addr),
        .o_port_wdata(i_port_wdata),
        .i_port_rdata(o_port_rdata)
    );
    always #2 i_core_clk = ~i_core_clk;
    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    function automatic logic [16:0] vec(input int k);
        return 17'h01000 + 17'(k);
    endfunction
    task automatic check(input string n, input logic [16:0] e,
        input logic [16:0] g);
        compares++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic close_out();
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
        core.get(a, rd);
        check($sformatf("port %h", a), {1'b0, e}, {1'b0, rd});
    endtask
    task automatic boot();
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        repeat (20) @(posedge i_core_clk);
        i_rst <= 1'b0;
    endtask
    // Pulse may land on the edge the caller just left
    task automatic await_pc(input logic [16:0] e);
        logic ok;
        ok = 1'b0;
        for (int i = 0; i < 12 && !ok; i++) begin
            #1;
            ok = (o_pc_load === 1'b1);
            if (!ok) @(posedge i_core_clk);
        end
        check("pc load", 17'h1, {16'h0, ok});
        check("pc value", e, {2'b00, o_pc_value});
    endtask
    task automatic service(input int k);
        logic ok;
        ok = 1'b0;
        for (int i = 0; i < 8 && !ok; i++) begin
            #1;
            ok = (o_int_take === 1'b1);
            if (!ok) @(posedge i_core_clk);
        end
        check("int take", 17'h1, {16'h0, ok});
        check("int level", 17'(k), {14'h0, o_int_level});
        @(posedge i_core_clk);
        i_int_ack <= 1'b1;
        @(posedge i_core_clk);
        i_int_ack <= 1'b0;
        await_pc(vec(k));
    endtask
    task automatic probe(input logic lk, input logic sc,
        input logic [14:0] fa, input logic [14:0] a);
        @(posedge i_core_clk);
        i_lookup <= lk;
        i_scan_rd <= sc;
        i_fetch_addr <= fa;
        i_lookup_addr <= a;
        i_scan_addr <= a;
        @(posedge i_core_clk);
        i_lookup <= 1'b0;
        i_scan_rd <= 1'b0;
        #1;
    endtask
    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            close_out();
        end
    end
    // ------------------------------------------------
    // Sequence
    // ------------------------------------------------
    initial begin
        {i_lookup, i_scan_rd, i_ram_wr, i_global_int_en, i_int_ack} = '0;
        {i_fetch_addr, i_lookup_addr, i_scan_addr, i_ram_addr} = '0;
        i_ram_wdata = '0;
        i_int_events = 8'h00;
        i_pin_levels = 40'h5AC3963CA5;
        i_port_f_levels = 8'h69;
        i_trim_value = 17'h00000;
        i_t1_count = 16'h1357;
        i_t2_count = 16'h2468;
        #1;
        dut.rom[15'h7FFF] = 17'h00800;
        dut.rom[15'h7FFE] = 17'h1837E;
        for (int k = 0; k < 8; k++) dut.rom[15'h7FF0 + 15'(k)] = vec(k);
        dut.rom[15'h0400] = 17'h1A5A5;
        dut.rom[15'h0500] = 17'h05555;
        dut.rom[15'h0600] = 17'h0C3C3;
        // Expansion words stay erased
        boot();
        await_pc(17'h00800);
        check("core run", 17'h1, {16'h0, o_core_run});
        check("pin drive", 17'h1, {16'h0, o_pin_oe === 40'h0});
        foreach (rst_addr[i]) rd_chk(rst_addr[i], 16'h0000);
        for (int k = 0; k < 5; k++) begin
            rd_chk(6'(8 * k), {8'h00, i_pin_levels[8 * k +: 8]});
        end
        rd_chk(6'h28, {8'h00, i_port_f_levels});
        rd_chk(6'h3B, i_t1_count);
        rd_chk(6'h3F, i_t2_count);
        foreach (rw_addr[i]) begin
            core.put(rw_addr[i], 16'hFFFF);
            rd_chk(rw_addr[i], rw_mask[i]);
        end
        check("pin drive", 17'h1, {16'h0, o_pin_oe === '1});
        check("port g", 17'h0FFFF, {1'b0, o_port_g});
        check("conv ctrl", 17'h0000F, {13'h0, o_conv_ctrl});
        check("t1 reload", 17'h0FFFF, {1'b0, o_t1_reload});
        check("t2 reload", 17'h0FFFF, {1'b0, o_t2_reload});
        core.put(6'h2F, 16'hFFFF);
        rd_chk(6'h2F, 16'h0000);
        core.put(6'h04, 16'h000F);
        core.put(6'h00, 16'h005A);
        rd_chk(6'h00, 16'h00AA);
        check("pin out", 17'h0005A, {9'h0, o_pin_out[7:0]});
        core.put(6'h30, 16'h0ABC);
        check("conv sample", 17'h0ABC0, {1'b0, o_conv_sample});
        rd_chk(6'h30, 16'h0000);
        core.put(6'h3D, 16'h1234);
        check("clk speed", 17'h01234, {1'b0, o_clk_speed});
        rd_chk(6'h3D, 16'h0000);
        rd_chk(6'h01, 16'h0000);
        core.put(6'h3B, 16'h0001);
        core.put(6'h3F, 16'h0002);
        check("t1 count wr", 17'h1, 17'(t1_wr_seen));
        check("t2 count wr", 17'h1, 17'(t2_wr_seen));
        probe(1'b0, 1'b1, 15'h0500, 15'h03FF);
        check("scan deny", 17'h1, {16'h0, o_scan_denied});
        check("fetch", 17'h05555, o_fetch_data);
        probe(1'b0, 1'b1, 15'h0500, 15'h0400);
        check("scan deny", 17'h0, {16'h0, o_scan_denied});
        check("scan data", 17'h1A5A5, o_scan_data);
        probe(1'b1, 1'b0, 15'h0500, 15'h0300);
        check("lookup fault", 17'h1, {16'h0, o_lookup_fault});
        probe(1'b1, 1'b0, 15'h0500, 15'h0600);
        check("lookup fault", 17'h0, {16'h0, o_lookup_fault});
        check("lookup data", 17'h0C3C3, o_lookup_data);
        @(posedge i_core_clk);
        i_ram_wr <= 1'b1;
        i_ram_addr <= 10'd639;
        i_ram_wdata <= 17'h1ABCD;
        @(posedge i_core_clk);
        i_ram_wr <= 1'b0;
        @(posedge i_core_clk);
        #1;
        check("ram word", 17'h1ABCD, o_ram_rdata);
        core.put(6'h39, 16'h0000);
        i_global_int_en <= 1'b1;
        core.put(6'h38, 16'h0008);
        core.put(6'h39, 16'h000C);
        service(3);
        repeat (4) @(posedge i_core_clk);
        #1;
        check("masked take", 17'h0, {16'h0, o_int_take});
        rd_chk(6'h39, 16'h0004);
        core.put(6'h39, 16'h0084);
        core.put(6'h38, 16'h00FF);
        service(2);
        service(7);
        check("int mask", 17'h000FF, {1'b0, o_int_gen_ctrl});
        for (int k = 0; k < 8; k++) begin
            @(posedge i_core_clk);
            i_int_events <= 8'(1 << k);
            @(posedge i_core_clk);
            i_int_events <= 8'h00;
            service(k);
        end
        i_global_int_en <= 1'b0;
        core.put(6'h39, 16'h005A);
        dut.rom[15'h7FFE] = 17'h1827E;
        boot();
        await_pc(17'h00800);
        rd_chk(6'h39, 16'h005A);
        rd_chk(6'h38, 16'h0000);
        probe(1'b0, 1'b1, 15'h0500, 15'h0600);
        check("scan deny", 17'h1, {16'h0, o_scan_denied});
        probe(1'b1, 1'b0, 15'h0500, 15'h0600);
        check("lookup fault", 17'h1, {16'h0, o_lookup_fault});
        close_out();
    end
endmodule
